// >>> verilog/wsf_top.sv
// Wakeup source flag unit: pin and internal source flags with register port
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module wsf_top (
  // Clock, reset, enable
  input  wire logic                         CLOCK,
  input  wire logic                         RST_N,
  input  wire logic                         CE,
  // Register port
  input  wire logic [wsf_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [wsf_pkg::DATA_W-1:0]   WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output logic      [wsf_pkg::DATA_W-1:0]   RDATA,
  // External wakeup pins, asynchronous
  input  wire logic [wsf_pkg::N_PINS-1:0]   WAKE_PIN,
  // Peripheral wake flags, same clock
  input  wire logic [wsf_pkg::N_MODS-1:0]   MOD_FLAG,
  // Power mode state from the mode controller
  input  wire logic                         LOW_LEAK_MODE,
  // Wake request and interrupt
  output logic                              WAKE_REQ,
  output logic                              IRQ
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wsf_pkg::wsf_bus_s                        bus;
  logic [wsf_pkg::N_PINS-1:0]               pin_sync;
  logic [wsf_pkg::N_PINS-1:0]               pin_hit;
  logic [wsf_pkg::N_PINS*wsf_pkg::EN_W-1:0] pin_en;

  // Configuration registers
  logic [wsf_pkg::DATA_W-1:0] pin_en_lo;
  logic [wsf_pkg::DATA_W-1:0] pin_en_hi;
  logic [wsf_pkg::DATA_W-1:0] mod_en;
  logic [wsf_pkg::DATA_W-1:0] next_pin_en_lo;
  logic [wsf_pkg::DATA_W-1:0] next_pin_en_hi;
  logic [wsf_pkg::DATA_W-1:0] next_mod_en;

  // Flag registers
  logic [wsf_pkg::N_PINS-1:0] pin_wake_flag;
  logic [wsf_pkg::N_PINS-1:0] next_pin_wake_flag;
  logic [wsf_pkg::N_MODS-1:0] internal_source_wake_flag;
  logic [wsf_pkg::N_MODS-1:0] mod_wake_prev;
  logic [wsf_pkg::N_MODS-1:0] next_mod_wake_prev;

  // Event terms
  logic [wsf_pkg::N_PINS-1:0] pin_set;
  logic [wsf_pkg::N_PINS-1:0] pin_clr;
  logic [wsf_pkg::N_MODS-1:0] mod_wake;
  logic                       pin_evt;
  logic                       src_evt;

  // Interrupt registers
  logic [wsf_pkg::IRQ_W-1:0]  irq_stat;
  logic [wsf_pkg::IRQ_W-1:0]  irq_mask;
  logic [wsf_pkg::IRQ_W-1:0]  next_irq_stat;
  logic [wsf_pkg::IRQ_W-1:0]  next_irq_mask;
  logic [wsf_pkg::IRQ_W-1:0]  irq_evt;

  // Output registers
  logic [wsf_pkg::DATA_W-1:0] next_rdata;
  logic                       next_wake_req;
  logic                       next_irq;

  // Address decode
  logic hit_pin_en_lo;
  logic hit_pin_en_hi;
  logic hit_mod_en;
  logic hit_pin_flag;
  logic hit_irq_stat;
  logic hit_irq_mask;

  // ----------------------------------------------------------------
  // Register port grouping and decode
  // ----------------------------------------------------------------

  // Bundle the port request
  assign bus.addr  = ADDR;
  assign bus.wdata = WDATA;
  assign bus.wr    = WR;
  assign bus.rd    = RD;

  // Strobe hit on one register offset, only while clocks are enabled
  function automatic logic reg_hit(logic                       en,
                                   logic                       strobe,
                                   logic [wsf_pkg::ADDR_W-1:0] addr,
                                   logic [wsf_pkg::ADDR_W-1:0] ofs);
    return en & strobe & (addr == ofs);
  endfunction

  // Write decode, gated by clock enable
  assign hit_pin_en_lo = reg_hit(CE, bus.wr, bus.addr, wsf_pkg::OFS_PIN_EN_LO);
  assign hit_pin_en_hi = reg_hit(CE, bus.wr, bus.addr, wsf_pkg::OFS_PIN_EN_HI);
  assign hit_mod_en    = reg_hit(CE, bus.wr, bus.addr, wsf_pkg::OFS_MOD_EN);
  assign hit_pin_flag  = reg_hit(CE, bus.wr, bus.addr, wsf_pkg::OFS_PIN_FLAG);
  assign hit_irq_mask  = reg_hit(CE, bus.wr, bus.addr, wsf_pkg::OFS_IRQ_MASK);

  // Read of the status register clears it
  assign hit_irq_stat  = reg_hit(CE, bus.rd, bus.addr, wsf_pkg::OFS_IRQ_STAT);

  // ----------------------------------------------------------------
  // Pin input path
  // ----------------------------------------------------------------

  // Two flops ahead of any logic on the pins
  wsf_sync #(
    .W (wsf_pkg::N_PINS)
  ) u_sync (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .ce      (CE),
    .d_async (WAKE_PIN),
    .q       (pin_sync)
  );

  // Enable fields: low byte pins 0..3, high byte pins 4..7
  assign pin_en = {pin_en_hi, pin_en_lo};

  // Edge detection per selected mode
  wsf_pin_detect #(
    .N (wsf_pkg::N_PINS)
  ) u_detect (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .ce        (CE),
    .pin_sync  (pin_sync),
    .en_fields (pin_en),
    .hit       (pin_hit)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Pin enable and module enable next values
  always_comb begin
    next_pin_en_lo = hit_pin_en_lo ? bus.wdata : pin_en_lo;
    next_pin_en_hi = hit_pin_en_hi ? bus.wdata : pin_en_hi;
    next_mod_en    = hit_mod_en    ? bus.wdata : mod_en;
  end

  // Configuration storage
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_en_lo <= wsf_pkg::RST_BYTE;
      pin_en_hi <= wsf_pkg::RST_BYTE;
      mod_en    <= wsf_pkg::RST_BYTE;
    end else begin
      pin_en_lo <= next_pin_en_lo;
      pin_en_hi <= next_pin_en_hi;
      mod_en    <= next_mod_en;
    end
  end

  // ----------------------------------------------------------------
  // Wake flags
  // ----------------------------------------------------------------

  // Mirror of peripheral flags, never stored here
  assign internal_source_wake_flag = MOD_FLAG;

  // Pin and internal wake terms, only while in a low-leakage mode
  always_comb begin
    pin_set  = pin_hit & {wsf_pkg::N_PINS{LOW_LEAK_MODE & CE}};
    pin_clr  = hit_pin_flag ? bus.wdata : '0;
    mod_wake = internal_source_wake_flag & mod_en
             & {wsf_pkg::N_MODS{LOW_LEAK_MODE}};
  end

  // Flag next values: set beats clear, clear only where a 1 is written
  always_comb begin
    next_pin_wake_flag = (pin_wake_flag & ~pin_clr) | pin_set;
    next_mod_wake_prev = CE ? mod_wake : mod_wake_prev;
    pin_evt            = |pin_set;
    src_evt            = CE & |(mod_wake & ~mod_wake_prev);
  end

  // Flag storage, cleared by the full chip reset; pin flags also cleared where a 1 is written
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pin_wake_flag <= '0;
      mod_wake_prev <= '0;
    end else begin
      pin_wake_flag <= next_pin_wake_flag;
      mod_wake_prev <= next_mod_wake_prev;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------

  // Sticky status, read clears, new event wins over the clear
  always_comb begin
    irq_evt                       = '0;
    irq_evt[wsf_pkg::IRQ_PIN_BIT] = pin_evt;
    irq_evt[wsf_pkg::IRQ_SRC_BIT] = src_evt;
    next_irq_stat = (hit_irq_stat ? wsf_pkg::RST_IRQ : irq_stat) | irq_evt;
    next_irq_mask = hit_irq_mask ? bus.wdata[wsf_pkg::IRQ_W-1:0] : irq_mask;
    next_irq      = CE ? |(next_irq_stat & next_irq_mask) : IRQ;
  end

  // Status and mask storage
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat <= wsf_pkg::RST_IRQ;
      irq_mask <= wsf_pkg::RST_IRQ;
      IRQ      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      IRQ      <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Wake request to the power mode controller
  // ----------------------------------------------------------------

  // Pulse on any enabled pin edge or new internal wake in low-leakage mode
  always_comb begin
    if (CE) begin
      next_wake_req = pin_evt | src_evt;
    end else begin
      next_wake_req = WAKE_REQ;
    end
  end

  // Wake request register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      WAKE_REQ <= 1'b0;
    end else begin
      WAKE_REQ <= next_wake_req;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Read mux; data stands one cycle after the strobe, zero otherwise while CE is high, held while CE is low
  always_comb begin
    next_rdata = '0;
    if (!CE) begin
      next_rdata = RDATA;
    end else if (bus.rd) begin
      case (bus.addr)
        wsf_pkg::OFS_PIN_EN_LO: next_rdata = pin_en_lo;
        wsf_pkg::OFS_PIN_EN_HI: next_rdata = pin_en_hi;
        wsf_pkg::OFS_MOD_EN:    next_rdata = mod_en;
        wsf_pkg::OFS_PIN_FLAG:  next_rdata = pin_wake_flag;
        wsf_pkg::OFS_SRC_FLAG:  next_rdata = internal_source_wake_flag;
        wsf_pkg::OFS_IRQ_STAT:  next_rdata[wsf_pkg::IRQ_W-1:0] = irq_stat;
        wsf_pkg::OFS_IRQ_MASK:  next_rdata[wsf_pkg::IRQ_W-1:0] = irq_mask;
        default:                next_rdata = '0;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= wsf_pkg::RST_BYTE;
    end else begin
      RDATA <= next_rdata;
    end
  end

endmodule

// >>> verilog/wsf_pkg.sv
// Constants, types and helpers shared by the wakeup source flag block
package wsf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_PINS = 8;
  localparam int N_MODS = 8;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int EN_W   = 2;
  localparam int IRQ_W  = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PIN_EN_LO = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_EN_HI = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_MOD_EN    = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_PIN_FLAG  = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_SRC_FLAG  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h11;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BYTE    = 8'h00;
  localparam logic [IRQ_W-1:0]  RST_IRQ     = 2'h0;
  localparam int                IRQ_PIN_BIT = 0;
  localparam int                IRQ_SRC_BIT = 1;
  localparam int                PINS_PER_EN = DATA_W / EN_W;

  // ----------------------------------------------------------------
  // Pin enable field encodings
  // ----------------------------------------------------------------
  typedef enum logic [EN_W-1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY  = 2'h3
  } wsf_edge_sel_e;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } wsf_bus_s;

  // ----------------------------------------------------------------
  // Edge match for one pin under its enable field
  // ----------------------------------------------------------------
  function automatic logic edge_hit(logic [EN_W-1:0] sel, logic rise, logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_ANY:  hit = rise | fall;
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

// >>> verilog/wsf_sync.sv
// Two flip-flop synchroniser for asynchronous wakeup pins
`timescale 1ns/1ps
module wsf_sync #(
  parameter int W = 8
) (
  // Clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // Next values: first stage feeds only the second
  always_comb begin
    next_meta = ce ? d_async : meta;
    next_q    = ce ? meta : q;
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule

// >>> verilog/wsf_pin_detect.sv
// Per-pin edge detector selected by the two-bit enable fields
`timescale 1ns/1ps
module wsf_pin_detect #(
  parameter int N = 8
) (
  // Clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // Synchronised pins and enable fields
  input  wire logic [N-1:0]               pin_sync,
  input  wire logic [N*wsf_pkg::EN_W-1:0] en_fields,
  // Detected wake edges
  output logic      [N-1:0]               hit
);

  // Two sync stages plus one held sample must fill before an edge counts
  localparam int WARM_W = 3;

  logic [N-1:0]      prev;
  logic [WARM_W-1:0] warm;
  logic [N-1:0]      next_prev;
  logic [WARM_W-1:0] next_warm;

  // Edge match; reset zeros in the pipeline never pass as an edge
  always_comb begin
    next_prev = ce ? pin_sync : prev;
    next_warm = ce ? {warm[WARM_W-2:0], 1'b1} : warm;
    for (int i = 0; i < N; i++) begin
      hit[i] = warm[WARM_W-1] & wsf_pkg::edge_hit(en_fields[i*wsf_pkg::EN_W +: wsf_pkg::EN_W],
                                                  pin_sync[i] & ~prev[i],
                                                  ~pin_sync[i] & prev[i]);
    end
  end

  // Previous sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
      warm <= '0;
    end else begin
      prev <= next_prev;
      warm <= next_warm;
    end
  end

endmodule

// >>> tb/wsf_top_props.sv
// Port-level checks for the wakeup source flag unit
`timescale 1ns/1ps
module wsf_top_props (
  // Clock, reset, enable
  input wire logic                       CLOCK,
  input wire logic                       RST_N,
  input wire logic                       CE,
  // Register port
  input wire logic [wsf_pkg::ADDR_W-1:0] ADDR,
  input wire logic [wsf_pkg::DATA_W-1:0] WDATA,
  input wire logic                       WR,
  input wire logic                       RD,
  input wire logic [wsf_pkg::DATA_W-1:0] RDATA,
  // Far side and mode
  input wire logic [wsf_pkg::N_PINS-1:0] WAKE_PIN,
  input wire logic [wsf_pkg::N_MODS-1:0] MOD_FLAG,
  input wire logic                       LOW_LEAK_MODE,
  // Wake request and interrupt
  input wire logic                       WAKE_REQ,
  input wire logic                       IRQ
);
  logic [1:0] mask;
  logic [1:0] next_mask;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // Shadow of the interrupt mask register
  always_comb begin
    next_mask = mask;
    if (CE && WR && ADDR == wsf_pkg::OFS_IRQ_MASK) begin
      next_mask = WDATA[1:0];
    end
  end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mask <= 2'h0;
    end else begin
      mask <= next_mask;
    end
  end

  AST_RD_SRC: assert property (CE && RD && ADDR == wsf_pkg::OFS_SRC_FLAG
    |=> RDATA == $past(MOD_FLAG)) else $error("source flag read differs from mirror");
  AST_RD_IDLE: assert property (CE && !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside read answer");
  AST_NO_WAKE: assert property (CE && !LOW_LEAK_MODE |=> !WAKE_REQ)
    else $error("wake request outside low leakage mode");
  AST_IRQ_MASK: assert property (CE && mask == 2'h0
    && !(WR && ADDR == wsf_pkg::OFS_IRQ_MASK) |=> !IRQ) else $error("irq with mask clear");
  AST_W1C_ALL: assert property (CE && WR && ADDR == wsf_pkg::OFS_PIN_FLAG
    && WDATA == 8'hFF && !LOW_LEAK_MODE ##1 CE && RD && ADDR == wsf_pkg::OFS_PIN_FLAG
    && !LOW_LEAK_MODE |=> RDATA == 8'h00) else $error("pin flags survive full clear");
  AST_W0_KEEP: assert property (CE && RD && ADDR == wsf_pkg::OFS_PIN_FLAG
    && !LOW_LEAK_MODE ##1 CE && WR && ADDR == wsf_pkg::OFS_PIN_FLAG && WDATA == 8'h00
    && !LOW_LEAK_MODE ##1 CE && RD && ADDR == wsf_pkg::OFS_PIN_FLAG && !LOW_LEAK_MODE
    |=> RDATA == $past(RDATA, 2)) else $error("zero write changed pin flags");
  AST_RST_VAL: assert property ($rose(RST_N) |-> RDATA == 8'h00 && !WAKE_REQ && !IRQ)
    else $error("outputs not cleared by reset");
  AST_STAT_CLR: assert property (CE && RD && ADDR == wsf_pkg::OFS_IRQ_STAT
    && !LOW_LEAK_MODE ##1 CE && !LOW_LEAK_MODE |=> !IRQ) else $error("irq after status read");
endmodule

bind wsf_top wsf_top_props i_props (
  .CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .WAKE_PIN(WAKE_PIN), .MOD_FLAG(MOD_FLAG), .LOW_LEAK_MODE(LOW_LEAK_MODE),
  .WAKE_REQ(WAKE_REQ), .IRQ(IRQ)
);

// >>> tb/wsf_partner.sv
// Far-side model: external wake pins and peripheral wake flags
`timescale 1ns/1ps
module wsf_partner (
  // Clock
  input  wire logic       clk,
  // Bench commands
  input  wire logic [7:0] pin_tgt,
  input  wire logic [7:0] mod_set,
  input  wire logic [7:0] mod_clr,
  input  wire logic [3:0] dly,
  // Far-side outputs
  output logic      [7:0] pins,
  output logic      [7:0] mflag
);
  int cnt = 0;

  // Peripheral flags held until cleared inside the peripheral
  always @(posedge clk) begin
    mflag <= (mflag | mod_set) & ~mod_clr;
  end
  // Pins follow the target after a chosen delay
  always @(posedge clk) begin
    if (pins === pin_tgt) begin
      cnt <= 0;
    end else if (cnt >= dly) begin
      pins <= pin_tgt;
      cnt  <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  initial begin
    pins  = 8'h00;
    mflag = 8'h00;
  end
endmodule

// >>> tb/tb_wsf_top.sv
// Self-checking bench for the wakeup source flag unit
`timescale 1ns/1ps
module tb_wsf_top;
  localparam logic [7:0] PF = wsf_pkg::OFS_PIN_FLAG;
  localparam logic [7:0] SF = wsf_pkg::OFS_SRC_FLAG;
  localparam logic [7:0] IS = wsf_pkg::OFS_IRQ_STAT;
  logic              clk;
  logic              rst_n;
  logic              ce;
  logic              llm;
  wsf_pkg::wsf_bus_s bus;
  logic [7:0]        rdata;
  logic [7:0]        pins;
  logic [7:0]        mflag;
  logic [7:0]        pin_tgt;
  logic [7:0]        mod_set;
  logic [7:0]        mod_clr;
  logic [3:0]        dly;
  logic              wake;
  logic              irq;
  logic [7:0]        v;
  logic [7:0]        p;
  logic [7:0]        c;
  logic [15:0]       f;
  logic [7:0]        regs [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h55};
  int                fails = 0;
  int                total_checks = 0;
  int                wakes = 0;
  int                w0;
  int                n;

  // Clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  wsf_top i_dut (
    .CLOCK(clk), .RST_N(rst_n), .CE(ce), .ADDR(bus.addr), .WDATA(bus.wdata), .WR(bus.wr),
    .RD(bus.rd), .RDATA(rdata), .WAKE_PIN(pins), .MOD_FLAG(mflag), .LOW_LEAK_MODE(llm),
    .WAKE_REQ(wake), .IRQ(irq)
  );
  wsf_partner i_far (
    .clk(clk), .pin_tgt(pin_tgt), .mod_set(mod_set), .mod_clr(mod_clr), .dly(dly),
    .pins(pins), .mflag(mflag)
  );

  // Count wake pulses
  always @(posedge clk) begin
    if (wake === 1'h1) wakes++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.wr    <= w;
    bus.rd    <= !w;
    bus.addr  <= a;
    bus.wdata <= d;
  endtask
  task automatic idle();
    @(posedge clk);
    bus.wr <= 1'h0;
    bus.rd <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    op(1'h0, a, 8'h00);
    idle();
    #1 d = rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'h1, a, d);
    idle();
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Clear all pin flags, read straight back
  task automatic clr();
    op(1'h1, PF, 8'hFF);
    rd(PF, v);
    chk(v, 8'h00);
  endtask
  function automatic logic hit_exp(input logic [1:0] m, input logic rise);
    return rise ? m[0] : m[1];
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    waitc(20000);
    fails++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rst_n = 1'h0; ce = 1'h1; llm = 1'h0; bus = '0;
    pin_tgt = 8'h00; mod_set = 8'h00; mod_clr = 8'h00; dly = 4'h0;
    v = 8'($urandom(32'h47E8C4DE));
    waitc(3);
    rst_n <= 1'h1;
    foreach (regs[i]) begin
      rd(regs[i], v);
      chk(v, 8'h00);
    end
    $display("reset values done");
    llm <= 1'h1;
    for (int m = 0; m < 4; m++) begin
      n = $urandom_range(7);
      dly <= 4'($urandom_range(3));
      f = 16'(m) << (2 * n);
      wr(8'h00, f[7:0]);
      wr(8'h01, f[15:8]);
      w0 = wakes;
      pin_tgt[n] <= 1'h1;
      waitc(12);
      rd(PF, v);
      chk(v, {7'h00, hit_exp(2'(m), 1'h1)} << n);
      chk(8'(wakes - w0), {7'h00, hit_exp(2'(m), 1'h1)});
      clr();
      pin_tgt[n] <= 1'h0;
      waitc(12);
      rd(PF, v);
      chk(v, {7'h00, hit_exp(2'(m), 1'h0)} << n);
      clr();
    end
    $display("edge modes done");
    p = 8'($urandom_range(255, 1));
    c = 8'($urandom);
    wr(8'h00, 8'hFF);
    wr(8'h01, 8'hFF);
    llm <= 1'h0;
    pin_tgt <= p;
    waitc(12);
    rd(PF, v);
    chk(v, 8'h00);
    pin_tgt <= 8'h00;
    waitc(12);
    llm <= 1'h1;
    pin_tgt <= p;
    waitc(12);
    llm <= 1'h0;
    rd(PF, v);
    chk(v, p);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    rd(PF, v);
    chk(v, p);
    ce <= 1'h0;
    wr(PF, 8'hFF);
    ce <= 1'h1;
    rd(PF, v);
    chk(v, p);
    wr(PF, c);
    rd(PF, v);
    chk(v, p & ~c);
    op(1'h0, PF, 8'h00);
    op(1'h1, PF, 8'h00);
    op(1'h0, PF, 8'h00);
    idle();
    #1 chk(rdata, p & ~c);
    clr();
    pin_tgt <= 8'h00;
    rd(IS, v);
    chk(v, 8'h01);
    $display("pin flags done");
    p = 8'($urandom);
    mod_set <= p;
    idle();
    mod_set <= 8'h00;
    rd(SF, v);
    chk(v, p);
    wr(SF, 8'hFF);
    rd(SF, v);
    chk(v, p);
    mod_clr <= 8'hFF;
    idle();
    mod_clr <= 8'h00;
    rd(SF, v);
    chk(v, 8'h00);
    wr(8'h02, 8'hFF);
    wr(8'h11, 8'h02);
    llm <= 1'h1;
    mod_set <= 8'h01;
    waitc(4);
    chk({7'h00, irq}, 8'h01);
    llm <= 1'h0;
    rd(IS, v);
    chk(v, 8'h02);
    rd(IS, v);
    chk(v, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(8'h11, 8'h00);
    mod_set <= 8'h00;
    mod_clr <= 8'h01;
    idle();
    mod_clr <= 8'h00;
    llm <= 1'h1;
    mod_set <= 8'h01;
    waitc(4);
    chk({7'h00, irq}, 8'h00);
    llm <= 1'h0;
    rd(IS, v);
    chk(v, 8'h02);
    mod_set <= 8'h00;
    mod_clr <= 8'hFF;
    $display("internal flags done");
    wr(8'h00, 8'hFF);
    llm <= 1'h1;
    pin_tgt <= 8'h0F;
    waitc(12);
    llm <= 1'h0;
    rd(PF, v);
    chk(v, 8'h0F);
    rst_n <= 1'h0;
    waitc(2);
    llm <= 1'h1;
    rst_n <= 1'h1;
    wr(8'h00, 8'hFF);
    waitc(4);
    llm <= 1'h0;
    rd(PF, v);
    chk(v, 8'h00);
    rd(8'h01, v);
    chk(v, 8'h00);
    rd(8'h02, v);
    chk(v, 8'h00);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
